// *** lsc_top.sv ***
// Line shading correction: per-pixel scaling against a stored white line,
// APB register slave, flash backup engine and output FIFO.
// Assumes a flash port that answers each request with a one-cycle ack.
// Notes on behaviour
// - Enabled: pixel times own factor, white->maximum percent level
// - Reference line kept; factors derived from it (the divide pass overwrites the reference with its factors)
// - Save request copies reference memory to flash
// - Restart reloads reference unless correction was off
// - Enable state persisted and restored at start
// - Disabled at shutdown: skip flash reload
// - Reference loaded from file enables correction
// - Pixels below minimum percent pass unchanged
// - Maximum percent sets scaling target level
// - Depth selectable 8 or 12 bits
// - Six channels each with gain and offset
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lsc_top (
    input wire logic mclk_in, // 40 MHz clock
    input wire logic srst_in, // Sync reset, active high
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error
    input wire logic pix_valid_in, // Digitized pixel valid
    output logic pix_ready_out, // Pixel accepted
    input wire lsc_pkg::lsc_pix_type pix_in, // Pixel and start of line
    output logic vid_valid_out, // Corrected pixel valid
    input wire logic vid_ready_in, // Host stream ready
    output lsc_pkg::lsc_pix_type vid_out, // Corrected pixel
    output lsc_pkg::lsc_flash_type flash_out, // Flash request
    input wire logic flash_ack_in, // Flash access done
    input wire logic [15:0] flash_rdata_in, // Flash read data
    output logic [8*lsc_pkg::NCH-1:0] afe_gain_out, // Channel gains
    output logic [8*lsc_pkg::NCH-1:0] afe_offset_out // Channel offsets
);
    localparam logic [10:0] LAST_IDX = 11'h7FF;

    // Factor memory: raw reference until the divide pass rewrites it
    logic [15:0] mem_r [lsc_pkg::NPIX];
    logic mem_we;
    logic [10:0] mem_wa;
    logic [15:0] mem_wd;

    lsc_pkg::lsc_state_type st_r, st_nxt;
    logic [10:0] idx_r, idx_nxt;
    logic [10:0] pidx_r, pidx_nxt;
    logic [10:0] fidx_nxt;
    logic enable_r, enable_nxt;
    logic depth12_r, depth12_nxt;
    logic [6:0] min_pct_r, min_pct_nxt, max_pct_r, max_pct_nxt;
    logic save_pend_r, save_pend_nxt, cap_pend_r, cap_pend_nxt;
    logic auto_en_r, auto_en_nxt;
    logic [23:0] q_r, q_nxt;
    logic [12:0] rem_r, rem_nxt;
    logic [4:0] step_r, step_nxt;
    logic [7:0] gain_r [lsc_pkg::NCH];
    logic [7:0] gain_nxt [lsc_pkg::NCH];
    logic [7:0] ofs_r [lsc_pkg::NCH];
    logic [7:0] ofs_nxt [lsc_pkg::NCH];
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    lsc_pkg::lsc_flash_type fl_r, fl_nxt;
    logic s_valid_r, s_valid_nxt;
    lsc_pkg::lsc_pix_type s_pix_r, s_pix_nxt;
    logic fifo_in_ready;

    logic [11:0] fs, min_lvl, target;
    logic [12:0] rem_sh;
    logic [27:0] prod;
    logic [15:0] scaled;
    logic wr_acc, setup, mapped, fl_done, take_pix;
    logic [15:0] fac;
    logic [7:0] reg_ofs;

    always_comb begin
        fs = depth12_r ? lsc_pkg::FS_12BIT : lsc_pkg::FS_8BIT;
        min_lvl = 12'((19'(fs) * 19'(min_pct_r)) / lsc_pkg::PCT_DIV);
        target = 12'((19'(fs) * 19'(max_pct_r)) / lsc_pkg::PCT_DIV);
        reg_ofs = {paddr_in[7:2], 2'b00};
        setup = psel_in && !penable_in;
        wr_acc = psel_in && penable_in && pready_r && pwrite_in && !pslverr_r;
        fl_done = fl_r.req && flash_ack_in;
        take_pix = pix_valid_in && pix_ready_out;
        mapped = (reg_ofs == lsc_pkg::OFS_CTRL) ||
            (reg_ofs == lsc_pkg::OFS_STATUS) ||
            (reg_ofs == lsc_pkg::OFS_LEVEL) ||
            (reg_ofs == lsc_pkg::OFS_REF_DATA);
        for (int i = 0; i < lsc_pkg::NCH; i++) begin
            if (reg_ofs == lsc_pkg::OFS_GAIN0 + 8'(4 * i) ||
                reg_ofs == lsc_pkg::OFS_OFFSET0 + 8'(4 * i)) begin
                mapped = 1'b1;
            end
        end

        // APB slave: answer in the first access cycle
        pready_nxt = setup;
        pslverr_nxt = setup && !mapped;
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = '0;
            case (reg_ofs)
                lsc_pkg::OFS_CTRL: begin
                    prdata_nxt[lsc_pkg::CTRL_ENABLE] = enable_r;
                    prdata_nxt[lsc_pkg::CTRL_DEPTH12] = depth12_r;
                end
                lsc_pkg::OFS_STATUS: begin
                    prdata_nxt[6:0] = st_r;
                    prdata_nxt[8] = enable_r;
                    prdata_nxt[26:16] = idx_r;
                end
                lsc_pkg::OFS_LEVEL: begin
                    prdata_nxt[lsc_pkg::LEVEL_MIN_LSB +: 7] = min_pct_r;
                    prdata_nxt[lsc_pkg::LEVEL_MAX_LSB +: 7] = max_pct_r;
                end
                default: begin
                    for (int i = 0; i < lsc_pkg::NCH; i++) begin
                        if (reg_ofs == lsc_pkg::OFS_GAIN0 + 8'(4 * i)) begin
                            prdata_nxt[7:0] = gain_r[i];
                        end
                        if (reg_ofs == lsc_pkg::OFS_OFFSET0 + 8'(4 * i)) begin
                            prdata_nxt[7:0] = ofs_r[i];
                        end
                    end
                end
            endcase
        end

        st_nxt = st_r;
        idx_nxt = idx_r;
        enable_nxt = enable_r;
        depth12_nxt = depth12_r;
        min_pct_nxt = min_pct_r;
        max_pct_nxt = max_pct_r;
        save_pend_nxt = save_pend_r;
        cap_pend_nxt = cap_pend_r;
        auto_en_nxt = auto_en_r;
        q_nxt = q_r;
        rem_nxt = rem_r;
        step_nxt = step_r;
        fl_nxt = fl_r;
        mem_we = 1'b0;
        mem_wa = idx_r;
        mem_wd = '0;
        for (int i = 0; i < lsc_pkg::NCH; i++) begin
            gain_nxt[i] = gain_r[i];
            ofs_nxt[i] = ofs_r[i];
        end

        // Register writes; commands only land while idle
        if (wr_acc) begin
            case (reg_ofs)
                lsc_pkg::OFS_CTRL: begin
                    depth12_nxt = pwdata_in[lsc_pkg::CTRL_DEPTH12];
                    if (st_r == lsc_pkg::ST_IDLE) begin
                        if (pwdata_in[lsc_pkg::CTRL_ENABLE] != enable_r) begin
                            enable_nxt = pwdata_in[lsc_pkg::CTRL_ENABLE];
                            st_nxt = lsc_pkg::ST_FLAG_WR;
                        end
                        save_pend_nxt = save_pend_r ||
                            pwdata_in[lsc_pkg::CTRL_SAVE];
                        cap_pend_nxt = cap_pend_r ||
                            pwdata_in[lsc_pkg::CTRL_CAPTURE];
                        if (pwdata_in[lsc_pkg::CTRL_LOAD_RST]) begin
                            idx_nxt = '0;
                        end
                    end
                end
                lsc_pkg::OFS_LEVEL: begin
                    min_pct_nxt = pwdata_in[lsc_pkg::LEVEL_MIN_LSB +: 7];
                    max_pct_nxt = pwdata_in[lsc_pkg::LEVEL_MAX_LSB +: 7];
                end
                lsc_pkg::OFS_REF_DATA: begin
                    if (st_r == lsc_pkg::ST_IDLE) begin
                        mem_we = 1'b1;
                        mem_wd = {4'h0, pwdata_in[11:0]};
                        idx_nxt = 11'(idx_r + 1'b1);
                        if (idx_r == LAST_IDX) begin
                            auto_en_nxt = 1'b1;
                            st_nxt = lsc_pkg::ST_DIV;
                        end
                    end
                end
                default: begin
                    for (int i = 0; i < lsc_pkg::NCH; i++) begin
                        if (reg_ofs == lsc_pkg::OFS_GAIN0 + 8'(4 * i)) begin
                            gain_nxt[i] = pwdata_in[7:0];
                        end
                        if (reg_ofs == lsc_pkg::OFS_OFFSET0 + 8'(4 * i)) begin
                            ofs_nxt[i] = pwdata_in[7:0];
                        end
                    end
                end
            endcase
        end

        rem_sh = {rem_r[11:0], q_r[23]};
        case (st_r)
            lsc_pkg::ST_IDLE: begin
                // A write that moves the state goes first; pending waits
                if (save_pend_r && st_nxt == lsc_pkg::ST_IDLE) begin
                    save_pend_nxt = 1'b0;
                    idx_nxt = '0;
                    st_nxt = lsc_pkg::ST_SAVE;
                end else if (cap_pend_r && st_nxt == lsc_pkg::ST_IDLE) begin
                    cap_pend_nxt = 1'b0;
                    idx_nxt = '0;
                    st_nxt = lsc_pkg::ST_CAPTURE;
                end
            end
            lsc_pkg::ST_BOOT_FLAG: begin
                fl_nxt.req = !fl_done;
                fl_nxt.we = 1'b0;
                fl_nxt.addr = lsc_pkg::FLASH_FLAG_ADDR;
                if (fl_done) begin
                    enable_nxt = flash_rdata_in[0];
                    idx_nxt = '0;
                    // Disabled at shutdown: memory stays unloaded
                    st_nxt = flash_rdata_in[0] ? lsc_pkg::ST_BOOT_LOAD :
                        lsc_pkg::ST_IDLE;
                end
            end
            lsc_pkg::ST_BOOT_LOAD, lsc_pkg::ST_SAVE: begin
                fl_nxt.req = !fl_done;
                fl_nxt.we = (st_r == lsc_pkg::ST_SAVE);
                fl_nxt.addr = {1'b0, idx_r};
                fl_nxt.wdata = mem_r[idx_r];
                if (fl_done) begin
                    mem_we = (st_r == lsc_pkg::ST_BOOT_LOAD);
                    mem_wd = flash_rdata_in;
                    idx_nxt = 11'(idx_r + 1'b1);
                    if (idx_r == LAST_IDX) begin
                        st_nxt = lsc_pkg::ST_IDLE;
                    end
                end
            end
            lsc_pkg::ST_FLAG_WR: begin
                fl_nxt.req = !fl_done;
                fl_nxt.we = 1'b1;
                fl_nxt.addr = lsc_pkg::FLASH_FLAG_ADDR;
                fl_nxt.wdata = {15'h0000, enable_r};
                if (fl_done) begin
                    st_nxt = lsc_pkg::ST_IDLE;
                end
            end
            lsc_pkg::ST_CAPTURE: begin
                // White line starts at the next start of line
                if (take_pix && (pix_in.sol || idx_r != '0)) begin
                    mem_we = 1'b1;
                    mem_wa = pix_in.sol ? 11'h000 : idx_r;
                    mem_wd = {4'h0, pix_in.data};
                    idx_nxt = pix_in.sol ? 11'h001 : 11'(idx_r + 1'b1);
                    if (!pix_in.sol && idx_r == LAST_IDX) begin
                        st_nxt = lsc_pkg::ST_DIV;
                    end
                end
            end
            lsc_pkg::ST_DIV: begin
                // Serial divide: factor = (target << 12) / reference
                if (step_r == '0) begin
                    q_nxt = {target, 12'h000};
                    rem_nxt = '0;
                    step_nxt = 5'(lsc_pkg::DIV_STEPS);
                end else begin
                    q_nxt = {q_r[22:0], 1'b0};
                    rem_nxt = rem_sh;
                    if (rem_sh >= {1'b0, mem_r[idx_r][11:0]} &&
                        mem_r[idx_r][11:0] != '0) begin
                        rem_nxt = 13'(rem_sh - {1'b0, mem_r[idx_r][11:0]});
                        q_nxt[0] = 1'b1;
                    end
                    step_nxt = 5'(step_r - 1'b1);
                    if (step_r == 5'h01) begin
                        mem_we = 1'b1;
                        mem_wd = (mem_r[idx_r][11:0] == '0 ||
                            q_nxt[23:16] != '0) ? lsc_pkg::FAC_MAX :
                            q_nxt[15:0];
                        idx_nxt = 11'(idx_r + 1'b1);
                        if (idx_r == LAST_IDX) begin
                            auto_en_nxt = 1'b0;
                            if (auto_en_r && !enable_r) begin
                                enable_nxt = 1'b1;
                                st_nxt = lsc_pkg::ST_FLAG_WR;
                            end else begin
                                st_nxt = lsc_pkg::ST_IDLE;
                            end
                        end
                    end
                end
            end
            default: begin
                st_nxt = lsc_pkg::ST_IDLE;
            end
        endcase

        // Pixel path: one register stage ahead of the FIFO
        pidx_nxt = pidx_r;
        fidx_nxt = pix_in.sol ? 11'h000 : pidx_r;
        fac = mem_r[fidx_nxt];
        prod = 28'(pix_in.data) * 28'(fac);
        scaled = prod[27:12];
        s_valid_nxt = s_valid_r && !fifo_in_ready;
        s_pix_nxt = s_pix_r;
        if (take_pix) begin
            pidx_nxt = 11'(fidx_nxt + 1'b1);
            s_valid_nxt = 1'b1;
            s_pix_nxt.sol = pix_in.sol;
            s_pix_nxt.data = pix_in.data;
            // Bypass during divide, boot load and capture; APB reference writes in idle are not bypassed
            if (enable_r && st_r != lsc_pkg::ST_DIV &&
                st_r != lsc_pkg::ST_BOOT_LOAD &&
                st_r != lsc_pkg::ST_CAPTURE &&
                pix_in.data >= min_lvl) begin
                s_pix_nxt.data = (scaled > {4'h0, fs}) ? fs :
                    scaled[11:0];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_r <= lsc_pkg::ST_BOOT_FLAG;
            idx_r <= '0;
            pidx_r <= '0;
            enable_r <= 1'b0;
            depth12_r <= 1'b0;
            min_pct_r <= lsc_pkg::MIN_PCT_RST;
            max_pct_r <= lsc_pkg::MAX_PCT_RST;
            save_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            auto_en_r <= 1'b0;
            q_r <= '0;
            rem_r <= '0;
            step_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            fl_r <= '0;
            s_valid_r <= 1'b0;
            s_pix_r <= '0;
            for (int i = 0; i < lsc_pkg::NCH; i++) begin
                gain_r[i] <= lsc_pkg::GAIN_RST;
                ofs_r[i] <= lsc_pkg::OFFSET_RST;
            end
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            pidx_r <= pidx_nxt;
            enable_r <= enable_nxt;
            depth12_r <= depth12_nxt;
            min_pct_r <= min_pct_nxt;
            max_pct_r <= max_pct_nxt;
            save_pend_r <= save_pend_nxt;
            cap_pend_r <= cap_pend_nxt;
            auto_en_r <= auto_en_nxt;
            q_r <= q_nxt;
            rem_r <= rem_nxt;
            step_r <= step_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            fl_r <= fl_nxt;
            s_valid_r <= s_valid_nxt;
            s_pix_r <= s_pix_nxt;
            for (int i = 0; i < lsc_pkg::NCH; i++) begin
                gain_r[i] <= gain_nxt[i];
                ofs_r[i] <= ofs_nxt[i];
            end
        end
        if (mem_we) begin
            mem_r[mem_wa] <= mem_wd;
        end
    end

    lsc_fifo #(
        .WIDTH(13),
        .DEPTH(lsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .in_valid_in(s_valid_r),
        .in_ready_out(fifo_in_ready),
        .in_data_in(s_pix_r),
        .out_valid_out(vid_valid_out),
        .out_ready_in(vid_ready_in),
        .out_data_out(vid_out)
    );

    // Stage holds a word only while the FIFO is full; that stalls the source
    assign pix_ready_out = !s_valid_r || fifo_in_ready;
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign flash_out = fl_r;
    for (genvar g = 0; g < lsc_pkg::NCH; g++) begin : g_afe
        assign afe_gain_out[8*g +: 8] = gain_r[g];
        assign afe_offset_out[8*g +: 8] = ofs_r[g];
    end
endmodule : lsc_top
`default_nettype wire

// *** lsc_pkg.sv ***
// Shared constants and carrier types for the line shading correction block.
// Assumes a 2048-pixel line and a 12-bit digitizer upstream.
package lsc_pkg;
    localparam int NPIX = 2048;
    localparam int IDX_W = 11;
    localparam int PIX_W = 12;
    localparam int FAC_W = 16;
    localparam int FRAC_W = 12;
    localparam int NCH = 6;
    localparam int FIFO_DEPTH = 32;
    localparam int FADDR_W = 12;
    localparam int DIV_STEPS = 24;
    localparam logic [11:0] FS_8BIT = 12'h0FF;
    localparam logic [11:0] FS_12BIT = 12'hFFF;
    localparam logic [15:0] FAC_MAX = 16'hFFFF;
    localparam logic [18:0] PCT_DIV = 19'h00064;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LEVEL = 8'h08;
    localparam logic [7:0] OFS_REF_DATA = 8'h0C;
    localparam logic [7:0] OFS_GAIN0 = 8'h20;
    localparam logic [7:0] OFS_OFFSET0 = 8'h40;
    // CTRL fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_DEPTH12 = 1;
    localparam int CTRL_SAVE = 2;
    localparam int CTRL_CAPTURE = 3;
    localparam int CTRL_LOAD_RST = 4;
    // LEVEL fields
    localparam int LEVEL_MIN_LSB = 0;
    localparam int LEVEL_MAX_LSB = 8;
    localparam logic [6:0] MIN_PCT_RST = 7'h0A;
    localparam logic [6:0] MAX_PCT_RST = 7'h5A;
    localparam logic [7:0] GAIN_RST = 8'h80;
    localparam logic [7:0] OFFSET_RST = 8'h00;
    // Flash word holding the persisted enable flag
    localparam logic [11:0] FLASH_FLAG_ADDR = 12'h800;

    typedef struct packed {
        logic sol;
        logic [11:0] data;
    } lsc_pix_type;

    typedef struct packed {
        logic req;
        logic we;
        logic [11:0] addr;
        logic [15:0] wdata;
    } lsc_flash_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_BOOT_FLAG = 7'h02,
        ST_BOOT_LOAD = 7'h04,
        ST_SAVE = 7'h08,
        ST_FLAG_WR = 7'h10,
        ST_CAPTURE = 7'h20,
        ST_DIV = 7'h40
    } lsc_state_type;
endpackage : lsc_pkg

// *** lsc_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lsc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    input wire logic mclk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic in_valid_in, // Write request
    output logic in_ready_out, // Not full
    input wire logic [WIDTH-1:0] in_data_in, // Write data
    output logic out_valid_out, // Not empty
    input wire logic out_ready_in, // Consumer takes word
    output logic [WIDTH-1:0] out_data_out // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    always_comb begin
        push = in_valid_in && (cnt_r != (AW+1)'(DEPTH));
        pop = out_ready_in && (cnt_r != '0);
        wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[rd_r];
endmodule : lsc_fifo
`default_nettype wire

// *** lsc_checker.sv ***
// Port checker for lsc_top: APB, flash and video timing.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lsc_checker (
    input wire logic mclk_in, // Clock
    input wire logic srst_in, // Reset
    input wire logic psel_in, // Select
    input wire logic penable_in, // Enable
    input wire logic pready_out, // Ready
    input wire logic vid_valid_out, // Video valid
    input wire logic vid_ready_in, // Video ready
    input wire lsc_pkg::lsc_pix_type vid_out, // Video word
    input wire lsc_pkg::lsc_flash_type flash_out, // Flash request
    input wire logic flash_ack_in, // Flash ack
    input wire logic [8*lsc_pkg::NCH-1:0] afe_gain_out // Gains
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);
    property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_one; pready_out |=> !pready_out; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_acc; pready_out |-> psel_in && penable_in; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access");
    property p_hold; flash_out.req && !flash_ack_in |=> $stable(flash_out);
    endproperty
    a_hold: assert property (p_hold) else $error("flash moved");
    property p_drop; flash_out.req && flash_ack_in |=> !flash_out.req;
    endproperty
    a_drop: assert property (p_drop) else $error("flash req kept");
    property p_vid; vid_valid_out && !vid_ready_in |=> $stable(vid_out);
    endproperty
    a_vid: assert property (p_vid) else $error("video head moved");
    property p_gain; $fell(srst_in) |-> afe_gain_out == {6{8'h80}};
    endproperty
    a_gain: assert property (p_gain) else $error("gain reset");
    property p_boot; $fell(srst_in) |-> ##[1:3]
        flash_out.req && flash_out.addr == lsc_pkg::FLASH_FLAG_ADDR;
    endproperty
    a_boot: assert property (p_boot) else $error("no flag read");
endmodule : lsc_checker
bind lsc_top lsc_checker u_chk (.mclk_in, .srst_in, .psel_in, .penable_in,
    .pready_out, .vid_valid_out, .vid_ready_in, .vid_out, .flash_out,
    .flash_ack_in, .afe_gain_out);
`default_nettype wire

// *** lsc_flash_model.sv ***
// Flash partner: 4096 words of 16 bits, ack one edge after a wait.
// Assumes the block holds each request until it sees the ack.
`timescale 1ns/1ps
`default_nettype none
module lsc_flash_model (
    input wire logic mclk_in, // Clock
    input wire lsc_pkg::lsc_flash_type flash_in, // Request
    output logic ack_out, // Done pulse
    output logic [15:0] rdata_out // Read word
);
    logic [15:0] mem [4096];
    logic wait_r = 1'b0;
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        ack_out = 1'b0;
        rdata_out = 16'hA5A5;
    end
    // Read word only valid with ack, so it toggles in between
    always @(posedge mclk_in) begin
        ack_out <= flash_in.req && wait_r && !ack_out;
        wait_r <= flash_in.req && !wait_r && !ack_out;
        rdata_out <= ~rdata_out;
        if (flash_in.req && wait_r && !ack_out) begin
            rdata_out <= mem[flash_in.addr];
            if (flash_in.we) mem[flash_in.addr] <= flash_in.wdata;
        end
    end
endmodule : lsc_flash_model
`default_nettype wire

// *** line_shading_correction_test.sv ***
// Testbench for lsc_top: registers, reference load, correction, flash.
// Assumes the flash model as partner and the checker bound to the top.
`timescale 1ns/1ps
`default_nettype none
module line_shading_correction_test;
    typedef struct {logic [3:0] c; logic [11:0] d, e;} lsc_row_type;
    logic mclk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out;
    logic pslverr_out, pix_valid_in, pix_ready_out, vid_valid_out;
    logic vid_ready_in, flash_ack_in, e;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic [15:0] flash_rdata_in;
    logic [47:0] afe_gain_out, afe_offset_out;
    lsc_pkg::lsc_pix_type pix_in, vid_out;
    lsc_pkg::lsc_flash_type flash_out;
    int bad_count, samples_checked, cycles;
    // Factor 7370 from a flat 2048 reference at 90 percent of 4095
    lsc_row_type rows [8] = '{'{4'h3, 12'h800, 12'hE65},
        '{4'h3, 12'h064, 12'h064}, '{4'h3, 12'h199, 12'h2DF},
        '{4'h3, 12'hFA0, 12'hFFF}, '{4'h1, 12'h0C8, 12'h0FF},
        '{4'h1, 12'h014, 12'h014}, '{4'h1, 12'h01E, 12'h035},
        '{4'h2, 12'h800, 12'h800}};
    lsc_top DUT (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .pix_valid_in, .pix_ready_out, .pix_in, .vid_valid_out,
        .vid_ready_in, .vid_out, .flash_out, .flash_ack_in,
        .flash_rdata_in, .afe_gain_out, .afe_offset_out);
    lsc_flash_model fm (.mclk_in, .flash_in(flash_out),
        .ack_out(flash_ack_in), .rdata_out(flash_rdata_in));
    always #12.5 mclk_in = ~mclk_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One idle edge after each transfer keeps drivers single per step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask : apb
    task automatic idle();
        do apb(1'b0, lsc_pkg::OFS_STATUS, 32'h0); while (q[6:0] !== 7'h01);
    endtask : idle
    task automatic px(input logic [11:0] d, input logic [11:0] x);
        pix_valid_in <= 1'b1;
        pix_in <= {1'b1, d};
        do @(posedge mclk_in); while (pix_ready_out !== 1'b1);
        pix_valid_in <= 1'b0;
        while (vid_valid_out !== 1'b1) @(posedge mclk_in);
        chk(32'(vid_out), {19'h0, 1'b1, x});
        vid_ready_in <= 1'b1;
        @(posedge mclk_in);
        vid_ready_in <= 1'b0;
    endtask : px
    task automatic tally_and_finish();
        $display("bad_count %0d samples_checked %0d", bad_count,
            samples_checked);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Long divide and flash copies dominate the run
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 95000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        {mclk_in, psel_in, penable_in, pwrite_in} = 4'h0;
        {pix_valid_in, vid_ready_in, srst_in} = 3'h1;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        pix_in = '0;
        repeat (8) @(posedge mclk_in);
        srst_in <= 1'b0;
        idle();
        chk(afe_gain_out[47:16], 32'h80808080);
        apb(1'b0, lsc_pkg::OFS_LEVEL, 32'h0);
        chk(q, 32'h00005A0A);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(e), 32'h1);
        for (int n = 0; n < 6; n++) begin
            apb(1'b1, lsc_pkg::OFS_GAIN0 + 8'(4 * n), 32'(n + 1));
            apb(1'b1, lsc_pkg::OFS_OFFSET0 + 8'(4 * n), 32'(n + 9));
            chk(32'(afe_gain_out[8*n+:8]), 32'(n + 1));
            chk(32'(afe_offset_out[8*n+:8]), 32'(n + 9));
        end
        apb(1'b1, lsc_pkg::OFS_CTRL, 32'h12);
        repeat (2048) apb(1'b1, lsc_pkg::OFS_REF_DATA, 32'h800);
        idle();
        chk(32'(q[8]), 32'h1);
        foreach (rows[i]) begin
            apb(1'b1, lsc_pkg::OFS_CTRL, 32'(rows[i].c));
            idle();
            px(rows[i].d, rows[i].e);
        end
        apb(1'b1, lsc_pkg::OFS_CTRL, 32'h3);
        idle();
        apb(1'b1, lsc_pkg::OFS_CTRL, 32'h7);
        idle();
        chk(32'(fm.mem[5]), 32'h1CCA);
        chk(32'(fm.mem[12'h800][0]), 32'h1);
        // New first factor: refilled only if enabled at shutdown
        for (int k = 1; k >= 0; k--) begin
            fm.mem[0] = 16'(32'h1000 << k);
            srst_in <= 1'b1;
            repeat (8) @(posedge mclk_in);
            srst_in <= 1'b0;
            idle();
            chk(32'(q[8]), 32'(k));
            apb(1'b1, lsc_pkg::OFS_CTRL, 32'h3);
            idle();
            px(12'h400, 12'h800);
            apb(1'b1, lsc_pkg::OFS_CTRL, 32'h2);
            idle();
        end
        tally_and_finish();
    end
endmodule : line_shading_correction_test
`default_nettype wire
